//--- rtl/bba_arbiter.sv
`timescale 1ns/1ps
module bba_arbiter
    import bba_pkg::*;
#(
    parameter int PorCycles = POR_CYCLES,
    parameter bit HasDefault = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic busReq0_n,
    input  wire logic busReq1_n,
    input  wire logic localReq,
    input  wire logic supplyValid,
    input  wire logic sysRstIn_n,
    input  wire logic selfTestDone,
    output logic      busAck0_n,
    output logic      busAck1_n,
    output logic      localGrant,
    output logic      defaultGrant,
    output logic      arbiterOwns,
    output logic      sysRstOut_n,
    output logic      sysRstOe,
    output logic      sysClk
);

    if (PorCycles < 1) begin : gPorCheck
        $error("PorCycles must be at least one");
    end

    bba_req_t   reqS1, reqS2, reqS3;
    logic [2:0] supS1, supS2, supS3;
    bba_state_t state;
    logic [31:0] porCount;
    logic       porDone;
    logic       sysRstActive;
    logic [15:0] phase;

    // Bus requests arrive active low, local request active high; all stored active high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reqS1 <= '0;
            reqS2 <= '0;
            reqS3 <= '0;
        end else begin
            reqS1 <= '{level0: ~busReq0_n, level1: ~busReq1_n, local_req: localReq};
            reqS2 <= reqS1;
            reqS3 <= reqS2;
        end
    end

    // Requests update only when stages two and three agree on all bits; else the old value stands
    bba_req_t req;
    bba_req_t reqHeld;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reqHeld <= '0;
        end else begin
            reqHeld <= (reqS2 == reqS3) ? reqS3 : reqHeld;
        end
    end
    assign req = reqHeld;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supS1 <= '0;
            supS2 <= '0;
            supS3 <= '0;
        end else begin
            supS1 <= {supplyValid, ~sysRstIn_n, selfTestDone};
            supS2 <= supS1;
            supS3 <= supS2;
        end
    end

    logic supOk, extRst, testOk;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supOk  <= 1'b0;
            extRst <= 1'b0;
            testOk <= 1'b0;
        end else begin
            if (supS2[2] == supS3[2]) supOk  <= supS3[2];
            if (supS2[1] == supS3[1]) extRst <= supS3[1];
            if (supS2[0] == supS3[0]) testOk <= supS3[0];
        end
    end

    // Power-on timer restarts whenever the supply leaves tolerance
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            porCount <= '0;
            porDone  <= 1'b0;
        end else if (!supOk) begin
            porCount <= '0;
            porDone  <= 1'b0;
        end else if (!porDone) begin
            porCount <= porCount + 32'd1;
            porDone  <= (porCount == 32'(PorCycles - 1));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sysRstOut_n <= 1'b0;
            sysRstOe    <= 1'b1;
            sysRstActive <= 1'b1;
        end else begin
            // Open drain: drive low only; self-test may extend the pulse
            sysRstOut_n  <= 1'b0;
            sysRstOe     <= !porDone || !testOk;
            sysRstActive <= !porDone || !testOk || extRst;
        end
    end

    logic busFree;
    assign busFree = (state == BBA_ARB_OWN) || (state == BBA_GNT_DEF);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= BBA_ARB_OWN;
        end else if (sysRstActive) begin
            state <= BBA_ARB_OWN;
        end else begin
            unique case (state)
                BBA_ARB_OWN, BBA_GNT_DEF: begin
                    if (req.level0)         state <= BBA_GNT_L0;
                    else if (req.level1)    state <= BBA_GNT_L1;
                    else if (req.local_req) state <= BBA_GNT_LOC;
                    else if (HasDefault)    state <= BBA_GNT_DEF;
                    else                    state <= BBA_ARB_OWN;
                end
                BBA_GNT_L0:  if (!req.level0)    state <= BBA_ARB_OWN;
                BBA_GNT_L1:  if (!req.level1)    state <= BBA_ARB_OWN;
                BBA_GNT_LOC: if (!req.local_req) state <= BBA_ARB_OWN;
                default:     state <= BBA_ARB_OWN;
            endcase
        end
    end

    // A grant stands only in its own state, for its own request, outside reset
    function automatic logic holdsGrant(input bba_state_t cur, input bba_state_t target,
                                        input logic lvl, input logic inRst);
        return (cur == target) && lvl && !inRst;
    endfunction : holdsGrant

    // Outputs registered; grant drops one cycle after the synchronised request falls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busAck0_n    <= 1'b1;
            busAck1_n    <= 1'b1;
            localGrant   <= 1'b0;
            defaultGrant <= 1'b0;
            arbiterOwns  <= 1'b1;
        end else begin
            busAck0_n    <= !holdsGrant(state, BBA_GNT_L0, req.level0, sysRstActive);
            busAck1_n    <= !holdsGrant(state, BBA_GNT_L1, req.level1, sysRstActive);
            localGrant   <= holdsGrant(state, BBA_GNT_LOC, req.local_req, sysRstActive);
            defaultGrant <= state == BBA_GNT_DEF && !req.level0 && !req.level1
                            && !req.local_req && !sysRstActive;
            arbiterOwns  <= busFree;
        end
    end

    // Fractional divider: 16 MHz average from 100 MHz, edges jitter by one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase  <= '0;
            sysClk <= 1'b0;
        end else begin
            phase  <= phase + SYSCLK_STEP;
            sysClk <= phase[15];
        end
    end

    // Grant exclusivity and pairing
    AST_ACK_EXCL: assert property (
        @(posedge clk) disable iff (!rst_n) !(!busAck0_n && !busAck1_n))
        else $error("both acknowledges asserted");

    AST_ACK0_REQ: assert property (
        @(posedge clk) disable iff (!rst_n) !busAck0_n |-> $past(req.level0))
        else $error("ack0 without request");

    AST_ACK1_REQ: assert property (
        @(posedge clk) disable iff (!rst_n) !busAck1_n |-> $past(req.level1))
        else $error("ack1 without request");

    AST_ACK0_PAIR: assert property (
        @(posedge clk) disable iff (!rst_n) !busAck0_n |-> $past(state == BBA_GNT_L0))
        else $error("ack0 outside level 0 grant");

    AST_ACK1_PAIR: assert property (
        @(posedge clk) disable iff (!rst_n) !busAck1_n |-> $past(state == BBA_GNT_L1))
        else $error("ack1 outside level 1 grant");

    AST_LOCAL_EXCL: assert property (
        @(posedge clk) disable iff (!rst_n)
        localGrant |-> (busAck0_n && busAck1_n && !defaultGrant))
        else $error("local grant overlaps another grant");

    AST_DEFAULT_EXCL: assert property (
        @(posedge clk) disable iff (!rst_n)
        defaultGrant |-> (busAck0_n && busAck1_n && !localGrant))
        else $error("default grant overlaps another grant");

    AST_OWNER_FLAG: assert property (
        @(posedge clk) disable iff (!rst_n)
        arbiterOwns |-> (busAck0_n && busAck1_n && !localGrant))
        else $error("bus reported free while granted");

    // Hold and release of a grant
    AST_ACK0_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!busAck0_n && req.level0 && !sysRstActive) |=> !busAck0_n)
        else $error("ack0 dropped while requested");

    AST_ACK1_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!busAck1_n && req.level1 && !sysRstActive) |=> !busAck1_n)
        else $error("ack1 dropped while requested");

    AST_ACK_RELEASE: assert property (
        @(posedge clk) disable iff (!rst_n) (!busAck1_n && !req.level1) |=> busAck1_n)
        else $error("ack1 not released");

    AST_ACK0_RELEASE: assert property (
        @(posedge clk) disable iff (!rst_n) (!busAck0_n && !req.level0) |=> busAck0_n)
        else $error("ack0 not released");

    AST_LOCAL_REQ: assert property (
        @(posedge clk) disable iff (!rst_n) localGrant |-> $past(req.local_req))
        else $error("local grant without request");

    AST_LOCAL_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n)
        (localGrant && req.local_req && !sysRstActive) |=> localGrant)
        else $error("local grant dropped while requested");

    AST_LOCAL_RELEASE: assert property (
        @(posedge clk) disable iff (!rst_n) (localGrant && !req.local_req) |=> !localGrant)
        else $error("local grant not released");

    AST_DEFAULT_YIELD: assert property (
        @(posedge clk) disable iff (!rst_n) (defaultGrant && req.level0) |=> !defaultGrant)
        else $error("default master did not yield");

    // Arbitration decisions
    AST_PRIORITY: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busFree && req.level0 && req.level1 && !sysRstActive) |=> state == BBA_GNT_L0)
        else $error("level 0 lost priority");

    AST_L1_GRANT: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busFree && !req.level0 && req.level1 && !sysRstActive) |=> state == BBA_GNT_L1)
        else $error("level 1 not chosen");

    AST_LEVEL: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busFree && req.level0 && !sysRstActive) |=> state == BBA_GNT_L0)
        else $error("standing level 0 request not served");

    AST_LOCAL_GRANT: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busFree && !req.level0 && !req.level1 && req.local_req && !sysRstActive)
        |=> state == BBA_GNT_LOC)
        else $error("local request not served");

    AST_DEFAULT_GRANT: assert property (
        @(posedge clk) disable iff (!rst_n)
        (HasDefault && busFree && !req.level0 && !req.level1 && !req.local_req
         && !sysRstActive) |=> state == BBA_GNT_DEF)
        else $error("idle bus not parked on default master");

    AST_ACK0_FROM_FREE: assert property (
        @(posedge clk) disable iff (!rst_n) $fell(busAck0_n) |-> $past(busFree, 2))
        else $error("ack0 issued while bus busy");

    AST_ACK1_FROM_FREE: assert property (
        @(posedge clk) disable iff (!rst_n) $fell(busAck1_n) |-> $past(busFree, 2))
        else $error("ack1 issued while bus busy");

    AST_DECIDE_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state == BBA_GNT_L0 && req.level0 && !sysRstActive) |=> state == BBA_GNT_L0)
        else $error("decision changed while request stands");

    AST_FREE_ONLY: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state == BBA_GNT_L1) |=> (state == BBA_GNT_L1 || state == BBA_ARB_OWN))
        else $error("grant changed hands directly");

    AST_SYNC_PATH: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(req.level0) |-> $past(reqS3.level0))
        else $error("request used before synchroniser");

    // Reset generation and bus inhibit
    AST_RST_NOGRANT: assert property (
        @(posedge clk) disable iff (!rst_n)
        sysRstActive |=> (busAck0_n && busAck1_n && !localGrant))
        else $error("grant during system reset");

    AST_RST_NODEFAULT: assert property (
        @(posedge clk) disable iff (!rst_n) sysRstActive |=> !defaultGrant)
        else $error("default grant during system reset");

    AST_RST_OWN: assert property (
        @(posedge clk) disable iff (!rst_n) sysRstActive |-> ##2 arbiterOwns)
        else $error("arbiter not owner after reset");

    AST_POR_LEN: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(porDone) |-> porCount == 32'(PorCycles))
        else $error("power-on pulse length wrong");

    AST_POR_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n) (supOk && !porDone) |=> sysRstOe)
        else $error("reset released before power-on timer ends");

    AST_SUPPLY: assert property (
        @(posedge clk) disable iff (!rst_n) !supOk |=> ##1 sysRstOe)
        else $error("reset not held on supply fault");

    AST_SUPPLY_TIMER: assert property (
        @(posedge clk) disable iff (!rst_n) !supOk |=> (porCount == '0 && !porDone))
        else $error("power-on timer not restarted");

    AST_RST_OE: assert property (
        @(posedge clk) disable iff (!rst_n) !testOk |=> sysRstOe)
        else $error("reset not held during self-test");

    // Divider runs 3 or 4 fast cycles per half period
    AST_SYSCLK_HIGH: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(sysClk) |-> sysClk[*3] ##[1:2] !sysClk)
        else $error("system clock high time out of range");

    AST_SYSCLK_LOW: assert property (
        @(posedge clk) disable iff (!rst_n) $fell(sysClk) |-> !sysClk[*3] ##[1:2] sysClk)
        else $error("system clock low time out of range");

endmodule : bba_arbiter

//--- rtl/bba_pkg.sv
package bba_pkg;

    localparam int CLK_MHZ        = 100;
    localparam int POR_MIN_MS     = 200;
    localparam int POR_MAX_MS     = 500;
    // Aim between the limits so clock tolerance cannot push us out
    localparam int POR_TARGET_MS  = 300;
    localparam int POR_CYCLES     = POR_TARGET_MS * 1000 * CLK_MHZ;
    localparam int POR_MIN_CYCLES = POR_MIN_MS * 1000 * CLK_MHZ;
    localparam int POR_MAX_CYCLES = POR_MAX_MS * 1000 * CLK_MHZ;
    localparam int SYSCLK_PERIOD_PS = 62500;
    localparam int CLK_PERIOD_PS    = 10000;
    // Phase step of a 16-bit accumulator: 2^16 * 10 ns / 62.5 ns
    localparam logic [15:0] SYSCLK_STEP =
        16'((64'd65536 * CLK_PERIOD_PS) / SYSCLK_PERIOD_PS);

    typedef enum logic [2:0] {
        BBA_ARB_OWN  = 3'b000,
        BBA_GNT_L0   = 3'b001,
        BBA_GNT_L1   = 3'b010,
        BBA_GNT_LOC  = 3'b011,
        BBA_GNT_DEF  = 3'b100
    } bba_state_t;

    typedef struct packed {
        logic level0;
        logic level1;
        logic local_req;
    } bba_req_t;

endpackage : bba_pkg

//--- tb/bba_master_model.sv
`timescale 1ns/1ps
module bba_master_model (
    input  wire logic clk,
    input  wire logic want,
    input  wire logic ack_n,
    output logic      req_n,
    output logic      owns
);
    initial req_n = 1'b1;
    // A fresh request waits until the old acknowledge has gone away
    // Acts on the rising edge so the bench's falling-edge stimulus is settled
    always @(posedge clk) begin
        if (req_n)
            req_n <= !(want && ack_n);
        else if (!want)
            req_n <= 1'b1;
    end
    assign owns = !req_n && !ack_n;
endmodule : bba_master_model

//--- tb/backplane_bus_allocation_tb.sv
`timescale 1ns/1ps
module backplane_bus_allocation_tb;
    import bba_pkg::*;
    logic clk, rst_n, localReq, supplyValid, selfTestDone, want0, want1, extRst_n;
    logic busReq0_n, busReq1_n, busAck0_n, busAck1_n, localGrant, defaultGrant;
    logic arbiterOwns, sysRstOut_n, sysRstOe, sysClk, owns0, owns1;
    // Open-drain wire with pull-up: low if either side pulls it low
    wire  sysRstIn_n = !(sysRstOe && !sysRstOut_n) && extRst_n;
    int   mismatches = 0;
    int   compares = 0;

    bba_arbiter #(.PorCycles(20), .HasDefault(1'b1)) dut (.clk(clk), .rst_n(rst_n),
        .busReq0_n(busReq0_n), .busReq1_n(busReq1_n), .localReq(localReq),
        .supplyValid(supplyValid), .sysRstIn_n(sysRstIn_n), .selfTestDone(selfTestDone),
        .busAck0_n(busAck0_n), .busAck1_n(busAck1_n), .localGrant(localGrant),
        .defaultGrant(defaultGrant), .arbiterOwns(arbiterOwns),
        .sysRstOut_n(sysRstOut_n), .sysRstOe(sysRstOe), .sysClk(sysClk));
    // One master per request line; both levels can request at once
    bba_master_model m0 (.clk(clk), .want(want0), .ack_n(busAck0_n), .req_n(busReq0_n),
        .owns(owns0));
    bba_master_model m1 (.clk(clk), .want(want1), .ack_n(busAck1_n), .req_n(busReq1_n),
        .owns(owns1));

    task automatic check(input logic act, input logic exp, input string msg);
        compares++;
        if (act !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask : cycles

    task automatic waitAck(input bit which, input logic lvl);
        for (int i = 0; i < 40 && (which ? busAck1_n : busAck0_n) !== lvl; i++)
            @(negedge clk);
        if ((which ? busAck1_n : busAck0_n) !== lvl) begin
            mismatches++;
            $display("unexpected at %0t: acknowledge wait timed out", $time);
        end
    endtask : waitAck

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic t_powerUp();
        cycles(15);
        check(busAck0_n, 1'b1, "ack during power-on reset");
        check(arbiterOwns, 1'b1, "arbiter not owner");
        check(sysRstOe, 1'b1, "power-on reset too short");
        check(sysRstOut_n, 1'b0, "reset drive level not low");
        cycles(25);
        check(sysRstOe, 1'b0, "power-on reset too long");
        waitAck(0, 1'b0);
        check(owns0, 1'b1, "no grant to level 0");
        want0 = 1'b0;
        waitAck(0, 1'b1);
        check(busAck0_n, 1'b1, "ack kept after release");
    endtask : t_powerUp

    task automatic t_priority();
        want0 = 1'b1;
        want1 = 1'b1;
        localReq = 1'b1;
        waitAck(0, 1'b0);
        check(busAck0_n, 1'b0, "level 0 not granted");
        check(busAck1_n, 1'b1, "two grants at once");
        check(localGrant, 1'b0, "local granted while busy");
        cycles(10);
        check(busAck0_n, 1'b0, "ack dropped while requested");
        want0 = 1'b0;
        waitAck(1, 1'b0);
        check(busAck0_n, 1'b1, "ack 0 not released");
        check(owns1, 1'b1, "level 1 not granted");
        want1 = 1'b0;
        cycles(10);
        check(localGrant, 1'b1, "local master not granted");
        localReq = 1'b0;
        cycles(10);
        check(defaultGrant, 1'b1, "idle bus not given to default");
        want1 = 1'b1;
        waitAck(1, 1'b0);
        check(defaultGrant, 1'b0, "default master did not yield");
        want1 = 1'b0;
        waitAck(1, 1'b1);
    endtask : t_priority

    task automatic t_resets();
        supplyValid = 1'b0;
        want0 = 1'b1;
        cycles(30);
        check(sysRstOe, 1'b1, "no reset on supply fault");
        check(busAck0_n, 1'b1, "grant under supply fault");
        supplyValid = 1'b1;
        cycles(40);
        check(sysRstOe, 1'b0, "reset stuck after supply back");
        extRst_n = 1'b0;
        cycles(4);
        waitAck(0, 1'b1);
        cycles(8);
        check(busAck0_n, 1'b1, "grant while reset driven elsewhere");
        extRst_n = 1'b1;
        waitAck(0, 1'b0);
        check(busAck0_n, 1'b0, "no grant after reset ends");
        want0 = 1'b0;
        waitAck(0, 1'b1);
        selfTestDone = 1'b0;
        cycles(8);
        check(sysRstOe, 1'b1, "reset not held during self-test");
        selfTestDone = 1'b1;
        cycles(8);
        check(sysRstOe, 1'b0, "reset kept after self-test");
    endtask : t_resets

    task automatic t_sysClock();
        int   edges;
        logic last;
        edges = 0;
        last  = sysClk;
        repeat (160) begin
            @(negedge clk);
            if (sysClk && !last)
                edges++;
            last = sysClk;
        end
        check(edges inside {[25:27]}, 1'b1, "system clock rate off");
    endtask : t_sysClock

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #100000;
        mismatches++;
        conclude();
    end

    initial begin
        {localReq, want1, rst_n} = '0;
        {supplyValid, selfTestDone, extRst_n, want0} = '1;
        cycles(6);
        rst_n = 1'b1;
        t_powerUp();
        t_priority();
        t_resets();
        t_sysClock();
        conclude();
    end
endmodule : backplane_bus_allocation_tb
